//--- include/rss_defines.svh
// constants for the radio strobe sequencer
`ifndef RSS_DEFINES_SVH
`define RSS_DEFINES_SVH

// instruction memory
`define RSS_DEPTH      24
`define RSS_LAST       5'h17
`define RSS_NOP        8'hc0
`define RSS_ALL_ONES   8'hff
`define RSS_BYTE_BITS  8'h08

// clocking: core steps at 8 MHz out of the 200 MHz clock
`define RSS_CLK_MHZ    200
`define RSS_CORE_MHZ   8

// opcode fields
`define RSS_F_S        6:4
`define RSS_F_N        3
`define RSS_F_C        2:0
`define RSS_F_W        4:0
`define RSS_F_M        2:0
`define RSS_F_CLASS    7:5
`define RSS_F_STROBE_SELECT_FIELD     4:0
`define RSS_CLS_IMM    3'h7

// opcode patterns
`define RSS_OP_SKIP    8'b0???????
`define RSS_OP_WAITW   8'b100?????
`define RSS_OP_RPT     8'b1010????
`define RSS_OP_INCMAX  8'b10110???
`define RSS_OP_STROBE_SELECT_FIELD    8'b110?????
`define RSS_OP_TIMER_COMPARE_WAIT  8'hb8
`define RSS_OP_INT     8'hb9
`define RSS_OP_LABEL   8'hba
`define RSS_OP_REGISTER_OVERFLOW_WAIT   8'hbb
`define RSS_OP_RAND    8'hbc
`define RSS_OP_Y_INCREMENT_OP    8'hbd
`define RSS_OP_Y_DECREMENT_OP    8'hbe
`define RSS_OP_Z_DECREMENT_OP    8'hbf

// strobe select codes
`define RSS_STROBE_SELECT_FIELD_START 5'h02
`define RSS_STROBE_SELECT_FIELD_STOP  5'h1f

// wait counts
`define RSS_WAIT32     6'h20

// random source
`define RSS_RNG_SEED   8'h5a
`define RSS_RNG_RST    8'h01
`define RSS_RNG_DELAY  3'h3

`endif

//--- include/rss_pkg.sv
// types shared by the radio strobe sequencer
package rss_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RUN,
    ST_WAIT_W,
    ST_WAIT_X,
    ST_WAIT_EV
  } rss_state_t;

  typedef struct packed {
    logic       valid;
    logic       imm;
    logic [4:0] sel;
  } rss_strobe_t;

  typedef struct packed {
    logic halt;
    logic wait_done;
    logic prog;
  } rss_irq_t;

endpackage

//--- hw/rss_rng.sv
// random byte source with a delayed refresh after each use
`timescale 1ns/1ps
`default_nettype none
`include "rss_defines.svh"

module rss_rng
(
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       nrst_i,
  // consumer side
  input  wire logic       use_i,
  output logic      [7:0] rand_o
);

  logic [7:0] lfsr_reg;
  logic [7:0] lfsr_next;
  logic [7:0] rand_reg;
  logic [7:0] rand_next;
  logic [2:0] dly_reg;
  logic [2:0] dly_next;

  // the held value refreshes only after a delay, so back to back uses match
  always_comb
  begin
    lfsr_next = {lfsr_reg[6:0],
                 lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
    rand_next = rand_reg;
    dly_next  = dly_reg;
    if (use_i)
      dly_next = `RSS_RNG_DELAY;
    else if (dly_reg != 3'h0)
    begin
      dly_next = dly_reg - 3'h1;
      if (dly_reg == 3'h1)
        rand_next = lfsr_reg;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      lfsr_reg <= `RSS_RNG_SEED;
      rand_reg <= `RSS_RNG_RST;
      dly_reg  <= 3'h0;
    end
    else
    begin
      lfsr_reg <= lfsr_next;
      rand_reg <= rand_next;
      dly_reg  <= dly_next;
    end
  end

  assign rand_o = rand_reg;

endmodule
`default_nettype wire

//--- hw/rss_sequencer.sv
// strobe sequencer core: port, program memory, execution and flags
//
// What this block does
// [R1] 24-byte instruction memory fetched during execution
// [R2] write pointer advances, saturates at last location
// [R3] either stop strobe returns write pointer to zero
// [R4] reset fills memory with no-operation opcode
// [R5] cpu writes program bytes even while running
// [R6] countdown decrements per overflow, zero halts run
// [R7] countdown loaded all ones never decrements
// [R8] cpu loads all ones if countdown unwanted
// [R9] immediate run strobe starts at location zero
// [R10] end, countdown, stops or far skip halt execution
// [R11] core steps at 8 MHz
// [R12] halt flag on end, stop strobes, countdown
// [R13] wait flag after overflow waits; interrupt instruction flag
// [R14] immediate strobe runs before pending stored instruction
// [R15] port read gives opcode, no-op during immediate
// [R16] end keeps program; stop strobes clear memory
// [R17] no timer wait between x update and use
// [R18] back to back random loads may repeat
// [R19] undefined opcodes act as no-operation
// [R20] opcode classes decoded from top bits
// [R21] fixed wait counts field overflows, zero means 32
// [R22] x-count wait skips on zero; compare wait
// [R23] random load fills y low bits of x
// [R24] loop back jumps to label when condition holds
// [R25] bounded increment loads bound when reaching it
// [R26] flags sticky until cleared, any drives irq
`timescale 1ns/1ps
`default_nettype none
`include "rss_defines.svh"

module rss_sequencer
(
  // clock and reset
  input  wire logic                mclk_i,
  input  wire logic                nrst_i,
  // cpu instruction port
  input  wire logic                port_wr_i,
  input  wire logic          [7:0] port_wdata_i,
  output logic               [7:0] port_rdata_o,
  // cpu parameter registers
  input  wire logic                x_wr_i,
  input  wire logic                y_wr_i,
  input  wire logic                z_wr_i,
  input  wire logic                t_wr_i,
  input  wire logic          [7:0] param_wdata_i,
  output logic               [7:0] param_x_o,
  output logic               [7:0] param_y_o,
  output logic               [7:0] param_z_o,
  output logic               [7:0] countdown_o,
  // mac timer events and branch conditions
  input  wire logic                ovf_i,
  input  wire logic                cmp_i,
  input  wire logic          [7:0] cond_i,
  // radio strobes
  output rss_pkg::rss_strobe_t     strobe_o,
  // interrupt flags
  input  wire rss_pkg::rss_irq_t   flag_clr_i,
  output rss_pkg::rss_irq_t        flags_o,
  output logic                     irq_o,
  output logic                     running_o
);

  localparam int DIV = `RSS_CLK_MHZ / `RSS_CORE_MHZ;

  // core step divider
  logic [4:0] div_reg;
  logic [4:0] div_next;
  logic       tick;

  always_comb
  begin
    div_next = (div_reg == 5'(DIV - 1)) ? 5'h00 : div_reg + 5'h01; // R11
  end

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
      div_reg <= 5'h00;
    else
      div_reg <= div_next;
  end

  assign tick = (div_reg == 5'(DIV - 1));

  // core state
  rss_pkg::rss_state_t  st_reg, st_next;
  rss_pkg::rss_strobe_t stb_reg, stb_next;
  rss_pkg::rss_irq_t    flg_reg, flg_next, flg_set;
  logic [4:0] pc_reg, pc_next, wp_reg, wp_next, lbl_reg, lbl_next;
  logic [4:0] imm_code_reg, imm_code_next;
  logic       lbl_ok_reg, lbl_ok_next, imm_reg, imm_next;
  logic [7:0] x_reg, x_next, y_reg, y_next, z_reg, z_next;
  logic [7:0] t_reg, t_next, rd_reg, rd_next;
  logic [5:0] wcnt_reg, wcnt_next, nxt;
  logic       irq_reg, irq_next, run_reg, run_next;
  logic       wr_imm, wr_prog, mem_clr, go, stop, clr_prog, rng_use;
  logic [7:0] op, mask, rand_val;
  logic [8:0] sum9;
  logic [7:0] mem_reg [`RSS_DEPTH];
  logic [7:0] mem_next [`RSS_DEPTH];

  assign wr_imm  = port_wr_i && (port_wdata_i[`RSS_F_CLASS] == `RSS_CLS_IMM);
  assign wr_prog = port_wr_i && !wr_imm; // R20
  assign op      = mem_reg[pc_reg]; // R1

  // next state of the sequencer core
  always_comb
  begin
    st_next = st_reg;
    pc_next = pc_reg;
    wp_next = wp_reg;
    lbl_next = lbl_reg;
    lbl_ok_next = lbl_ok_reg;
    imm_next = imm_reg;
    imm_code_next = imm_code_reg;
    x_next = x_wr_i ? param_wdata_i : x_reg;
    y_next = y_wr_i ? param_wdata_i : y_reg;
    z_next = z_wr_i ? param_wdata_i : z_reg;
    t_next = t_wr_i ? param_wdata_i : t_reg;
    wcnt_next = wcnt_reg;
    stb_next = '0;
    flg_set = '0;
    mem_clr = 1'b0;
    rng_use = 1'b0;
    go = 1'b0;
    stop = 1'b0;
    clr_prog = 1'b0;
    nxt = {1'b0, pc_reg} + 6'h01;
    mask = `RSS_ALL_ONES;
    sum9 = {1'b0, y_reg} + 9'h001;
    if (wr_prog && wp_reg != `RSS_LAST)
      wp_next = wp_reg + 5'h01; // R2
    // countdown only runs once a program has started
    if (st_reg != rss_pkg::ST_IDLE)
    begin
      if (ovf_i && t_reg != `RSS_ALL_ONES && t_reg != 8'h00 && !t_wr_i)
        t_next = t_reg - 8'h01; // R6 R7
      if (t_reg == 8'h00)
      begin
        stop = 1'b1; // R10
        flg_set.halt = 1'b1; // R12
      end
    end
    // waits watch timer events at full rate, not only on core steps
    unique case (st_reg)
      rss_pkg::ST_WAIT_W:
        if (ovf_i)
        begin
          wcnt_next = wcnt_reg - 6'h01;
          if (wcnt_reg == 6'h01)
          begin
            go = 1'b1; // R21
            flg_set.wait_done = 1'b1; // R13
          end
        end
      rss_pkg::ST_WAIT_X:
        if (ovf_i)
        begin
          x_next = x_reg - 8'h01; // R22
          if (x_reg == 8'h01)
          begin
            go = 1'b1;
            flg_set.wait_done = 1'b1; // R13
          end
        end
      rss_pkg::ST_WAIT_EV:
        go = cmp_i; // R22
      rss_pkg::ST_IDLE, rss_pkg::ST_RUN: ;
    endcase
    if (tick && imm_reg)
    begin
      // immediate strobe takes the step, the stored one waits
      imm_next = 1'b0; // R14
      stb_next = '{valid: 1'b1, imm: 1'b1, sel: imm_code_reg};
      if (imm_code_reg == `RSS_STROBE_SELECT_FIELD_START)
      begin
        st_next = rss_pkg::ST_RUN; // R9
        pc_next = 5'h00;
        lbl_ok_next = 1'b0;
        go = 1'b0; // a wait ending now must not move pc off zero
      end
      else if (imm_code_reg == `RSS_STROBE_SELECT_FIELD_STOP)
      begin
        stop = 1'b1; // R10
        clr_prog = 1'b1;
        flg_set.halt = 1'b1; // R12
      end
    end
    else if (tick && st_reg == rss_pkg::ST_RUN)
    begin
      casez (op)
        `RSS_OP_SKIP:
        begin
          if (cond_i[op[`RSS_F_C]] ^ op[`RSS_F_N])
            nxt = nxt + {3'h0, op[`RSS_F_S]};
          go = 1'b1;
        end
        `RSS_OP_WAITW:
        begin
          wcnt_next = (op[`RSS_F_W] == 5'h00) ? `RSS_WAIT32
                                              : {1'b0, op[`RSS_F_W]}; // R21
          st_next = rss_pkg::ST_WAIT_W;
        end
        `RSS_OP_RPT:
        begin
          if (lbl_ok_reg && (cond_i[op[`RSS_F_C]] ^ op[`RSS_F_N]))
            nxt = {1'b0, lbl_reg}; // R24
          go = 1'b1;
        end
        `RSS_OP_INCMAX:
        begin
          y_next = (sum9 >= {6'h00, op[`RSS_F_M]}) ? {5'h00, op[`RSS_F_M]}
                                                   : sum9[7:0]; // R25
          go = 1'b1;
        end
        `RSS_OP_TIMER_COMPARE_WAIT:
          st_next = rss_pkg::ST_WAIT_EV; // R22
        `RSS_OP_INT:
        begin
          flg_set.prog = 1'b1; // R13
          go = 1'b1;
        end
        `RSS_OP_LABEL:
        begin
          lbl_next = (pc_reg == `RSS_LAST) ? pc_reg : pc_reg + 5'h01;
          lbl_ok_next = 1'b1;
          go = 1'b1;
        end
        `RSS_OP_REGISTER_OVERFLOW_WAIT:
          if (x_reg == 8'h00)
            go = 1'b1; // R22
          else
            st_next = rss_pkg::ST_WAIT_X;
        `RSS_OP_RAND:
        begin
          if (y_reg != 8'h00 && y_reg < `RSS_BYTE_BITS)
            mask = `RSS_ALL_ONES >> (`RSS_BYTE_BITS - y_reg);
          x_next = rand_val & mask; // R23
          rng_use = 1'b1; // R18
          go = 1'b1;
        end
        `RSS_OP_Y_INCREMENT_OP:
        begin
          y_next = y_reg + 8'h01;
          go = 1'b1;
        end
        `RSS_OP_Y_DECREMENT_OP:
        begin
          y_next = y_reg - 8'h01;
          go = 1'b1;
        end
        `RSS_OP_Z_DECREMENT_OP:
        begin
          z_next = z_reg - 8'h01;
          go = 1'b1;
        end
        `RSS_OP_STROBE_SELECT_FIELD:
        begin
          stb_next = '{valid: 1'b1, imm: 1'b0, sel: op[`RSS_F_STROBE_SELECT_FIELD]};
          if (op[`RSS_F_STROBE_SELECT_FIELD] == `RSS_STROBE_SELECT_FIELD_STOP)
          begin
            stop = 1'b1; // R10
            clr_prog = 1'b1;
            flg_set.halt = 1'b1; // R12
          end
          else
            go = 1'b1;
        end
        default:
          go = 1'b1; // R19
      endcase
    end
    // advance, or end the run past the last location
    if (go && !stop)
    begin
      st_next = rss_pkg::ST_RUN;
      if (nxt > {1'b0, `RSS_LAST})
      begin
        st_next = rss_pkg::ST_IDLE; // R10 R16
        if (pc_reg == `RSS_LAST && op[7:6] != 2'b00)
          flg_set.halt = 1'b1; // R12
      end
      else
        pc_next = nxt[4:0];
    end
    if (stop)
      st_next = rss_pkg::ST_IDLE;
    if (clr_prog)
    begin
      wp_next = 5'h00; // R3
      mem_clr = 1'b1; // R16
    end
    // a strobe written on the step that retires the last one is kept
    if (wr_imm)
    begin
      imm_next = 1'b1;
      imm_code_next = port_wdata_i[`RSS_F_STROBE_SELECT_FIELD];
    end
    flg_next = (flg_reg & ~flag_clr_i) | flg_set; // R26
    irq_next = |flg_next; // R26
    run_next = (st_next != rss_pkg::ST_IDLE);
    rd_next = (imm_next || !run_next) ? `RSS_NOP : mem_reg[pc_next]; // R15
  end

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      st_reg <= rss_pkg::ST_IDLE;
      pc_reg <= 5'h00;
      wp_reg <= 5'h00;
      lbl_reg <= 5'h00;
      lbl_ok_reg <= 1'b0;
      imm_reg <= 1'b0;
      imm_code_reg <= 5'h00;
      x_reg <= 8'h00;
      y_reg <= 8'h00;
      z_reg <= 8'h00;
      t_reg <= 8'h00;
      wcnt_reg <= 6'h00;
      stb_reg <= '0;
      flg_reg <= '0;
      irq_reg <= 1'b0;
      run_reg <= 1'b0;
      rd_reg <= `RSS_NOP;
    end
    else
    begin
      st_reg <= st_next;
      pc_reg <= pc_next;
      wp_reg <= wp_next;
      lbl_reg <= lbl_next;
      lbl_ok_reg <= lbl_ok_next;
      imm_reg <= imm_next;
      imm_code_reg <= imm_code_next;
      x_reg <= x_next;
      y_reg <= y_next;
      z_reg <= z_next;
      t_reg <= t_next;
      wcnt_reg <= wcnt_next;
      stb_reg <= stb_next;
      flg_reg <= flg_next;
      irq_reg <= irq_next;
      run_reg <= run_next;
      rd_reg <= rd_next;
    end
  end

  // program memory, one entry per generate step; clearing beats a write
  for (genvar g = 0; g < `RSS_DEPTH; g++)
  begin : g_mem
    always_comb
    begin
      mem_next[g] = mem_reg[g];
      if (mem_clr)
        mem_next[g] = `RSS_NOP; // R16
      else if (wr_prog && wp_reg == 5'(g))
        mem_next[g] = port_wdata_i; // R2
    end

    always_ff @(posedge mclk_i)
    begin
      if (!nrst_i)
        mem_reg[g] <= `RSS_NOP; // R4
      else
        mem_reg[g] <= mem_next[g];
    end
  end

  rss_rng u_rng
  (
    .mclk_i (mclk_i),
    .nrst_i (nrst_i),
    .use_i  (rng_use),
    .rand_o (rand_val)
  );

  assign port_rdata_o = rd_reg;
  assign param_x_o    = x_reg;
  assign param_y_o    = y_reg;
  assign param_z_o    = z_reg;
  assign countdown_o  = t_reg;
  assign strobe_o     = stb_reg;
  assign flags_o      = flg_reg;
  assign irq_o        = irq_reg;
  assign running_o    = run_reg;

  // checks
  sequence s_imm_step(logic [4:0] c);
    tick && imm_reg && imm_code_reg == c;
  endsequence

  a_wp_saturates: // R2
    assert property (@(posedge mclk_i) disable iff (!nrst_i)
      wr_prog && wp_reg == `RSS_LAST && !mem_clr |=> wp_reg == `RSS_LAST)
    else $error("write pointer left last location");
  a_wp_steps: // R2
    assert property (@(posedge mclk_i) disable iff (!nrst_i)
      wr_prog && wp_reg != `RSS_LAST && !mem_clr
      |=> wp_reg == $past(wp_reg) + 5'h01)
    else $error("write pointer did not advance");
  a_mem_reset_nop: // R4
    assert property (@(posedge mclk_i) $past(!nrst_i) && nrst_i
      |-> mem_reg[0] == `RSS_NOP && mem_reg[`RSS_DEPTH-1] == `RSS_NOP)
    else $error("memory not filled with no-op at reset");
  a_start_runs: // R9
    assert property (@(posedge mclk_i) disable iff (!nrst_i)
      s_imm_step(`RSS_STROBE_SELECT_FIELD_START) |=> st_reg == rss_pkg::ST_RUN
      && pc_reg == 5'h00 ##1 running_o)
    else $error("start strobe did not start at zero");
  a_stop_clears: // R3
    assert property (@(posedge mclk_i) disable iff (!nrst_i)
      s_imm_step(`RSS_STROBE_SELECT_FIELD_STOP) |=> !run_reg && wp_reg == 5'h00
      && mem_reg[0] == `RSS_NOP && flg_reg.halt)
    else $error("stop strobe did not halt and clear");
  a_step_period: // R11
    assert property (@(posedge mclk_i) disable iff (!nrst_i)
      tick |=> !tick [*8] ##17 tick)
    else $error("core step not every 25 clocks");
  a_count_frozen: // R7
    assert property (@(posedge mclk_i) disable iff (!nrst_i)
      t_reg == `RSS_ALL_ONES && !t_wr_i |=> t_reg == `RSS_ALL_ONES)
    else $error("all-ones countdown changed");
  a_count_dec: // R6
    assert property (@(posedge mclk_i) disable iff (!nrst_i)
      st_reg != rss_pkg::ST_IDLE && ovf_i && !t_wr_i
      && t_reg != `RSS_ALL_ONES && t_reg != 8'h00
      |=> t_reg == $past(t_reg) - 8'h01)
    else $error("countdown missed an overflow");
  a_read_nop_imm: // R15
    assert property (@(posedge mclk_i) disable iff (!nrst_i)
      imm_reg |-> port_rdata_o == `RSS_NOP)
    else $error("read during immediate not no-op");
  a_irq_follows: // R26
    assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (|flg_reg) && flag_clr_i == '0
      |=> irq_o && (flg_reg & $past(flg_reg)) == $past(flg_reg))
    else $error("flag lost or irq not raised");

endmodule
`default_nettype wire

//--- test/rss_timer_model.sv
// mac timer model: periodic overflow pulse and compare level
`timescale 1ns/1ps
`default_nettype none

module rss_timer_model
#(
  parameter int PERIOD = 40
)
(
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic nrst_i,
  // timer events
  output logic      ovf_o,
  output logic      cmp_o
);
  int cnt_reg;

  // free-running count; overflow is a one-cycle pulse
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      cnt_reg <= 0;
      ovf_o   <= 1'b0;
    end
    else
    begin
      cnt_reg <= (cnt_reg == PERIOD - 1) ? 0 : cnt_reg + 1;
      ovf_o   <= (cnt_reg == PERIOD - 1);
    end
  end

  // compare level: timer at or past its midpoint
  assign cmp_o = (cnt_reg >= PERIOD / 2);
endmodule
`default_nettype wire

//--- test/rss_sequencer_tb.sv
// self-checking bench for the strobe sequencer
`timescale 1ns/1ps
`default_nettype none
`include "rss_defines.svh"

module rss_sequencer_tb;
  logic                 mclk_i = 1'b0;
  logic                 nrst_i = 1'b0;
  logic                 port_wr_i = 1'b0;
  logic                 x_wr_i = 1'b0;
  logic                 y_wr_i = 1'b0;
  logic                 z_wr_i = 1'b0;
  logic                 t_wr_i = 1'b0;
  logic           [7:0] port_wdata_i = 8'h00;
  logic           [7:0] param_wdata_i = 8'h00;
  logic           [7:0] cond_i = 8'h00;
  rss_pkg::rss_irq_t    flag_clr_i = '0;
  logic           [7:0] port_rdata_o, param_x_o, param_y_o, param_z_o;
  logic           [7:0] countdown_o;
  rss_pkg::rss_strobe_t strobe_o;
  rss_pkg::rss_irq_t    flags_o;
  logic                 irq_o, running_o, ovf_i, cmp_i;
  int                   errors = 0;
  int                   check_count = 0;
  int                   wp = 0;
  logic           [7:0] mem [24];
  logic           [6:0] sq [$];
  logic           [7:0] ry, rz, y1, y2;
  logic           [7:0] prog_c [7] = '{8'hc3, 8'hb9, 8'h84, 8'hbd,
                                       8'hb3, 8'hbf, 8'hbb};

  // 200 MHz clock
  always #2.5 mclk_i = ~mclk_i;

  rss_sequencer dut (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .port_wr_i(port_wr_i), .port_wdata_i(port_wdata_i),
    .port_rdata_o(port_rdata_o), .x_wr_i(x_wr_i), .y_wr_i(y_wr_i),
    .z_wr_i(z_wr_i), .t_wr_i(t_wr_i), .param_wdata_i(param_wdata_i),
    .param_x_o(param_x_o), .param_y_o(param_y_o), .param_z_o(param_z_o),
    .countdown_o(countdown_o), .ovf_i(ovf_i), .cmp_i(cmp_i),
    .cond_i(cond_i), .strobe_o(strobe_o), .flag_clr_i(flag_clr_i),
    .flags_o(flags_o), .irq_o(irq_o), .running_o(running_o));

  rss_timer_model tmr (.mclk_i(mclk_i), .nrst_i(nrst_i), .ovf_o(ovf_i),
    .cmp_o(cmp_i));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    if (errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // model of the memory: a stop empties it and rewinds the pointer
  task automatic wipe;
    wp = 0;
    foreach (mem[j]) mem[j] = `RSS_NOP;
  endtask

  // one port write; immediates are noted, stored bytes go to the model
  task automatic wr(input logic [7:0] b);
    @(posedge mclk_i);
    port_wr_i    <= 1'b1;
    port_wdata_i <= b;
    @(posedge mclk_i);
    port_wr_i    <= 1'b0;
    if (b[7:5] == `RSS_CLS_IMM)
    begin
      sq.push_back({2'b11, b[4:0]});
      if (b[4:0] == `RSS_STROBE_SELECT_FIELD_STOP)
      begin
        wipe;
        // let the stop take its core step before stored bytes follow
        repeat (26) @(posedge mclk_i);
      end
    end
    else
    begin
      mem[wp] = b;
      if (wp < 23)
        wp++;
    end
  endtask

  // k selects countdown, x, y or z
  task automatic setp(input int k, input logic [7:0] d);
    @(posedge mclk_i);
    param_wdata_i <= d;
    t_wr_i        <= (k == 0);
    x_wr_i        <= (k == 1);
    y_wr_i        <= (k == 2);
    z_wr_i        <= (k == 3);
    @(posedge mclk_i);
    {t_wr_i, x_wr_i, y_wr_i, z_wr_i} <= 4'h0;
  endtask

  task automatic clr;
    @(posedge mclk_i);
    flag_clr_i <= 3'b111;
    @(posedge mclk_i);
    flag_clr_i <= 3'b000;
    repeat (2) @(posedge mclk_i);
    #1 check({5'h0, flags_o}, 8'h00);
    check({7'h0, irq_o}, 8'h00);
  endtask

  // expected strobe of one executed location
  task automatic note(input int i);
    if (mem[i][7:5] == 3'b110)
      sq.push_back({2'b10, mem[i][4:0]});
    if (mem[i] == 8'hdf)
      wipe;
  endtask

  // start, note locations, optionally inject an immediate, await halt
  task automatic run(input int split, input int upto, input bit imm);
    int n;
    n = 0;
    wr(8'he2);
    for (int i = 0; i < split; i++)
      note(i);
    while (running_o !== 1'b1 && n < 100)
    begin
      @(negedge mclk_i);
      n++;
    end
    if (imm)
    begin
      // the four-overflow wait at location two is surely active here
      repeat (100) @(posedge mclk_i);
      #1 check(port_rdata_o, 8'h84);
      wr(8'he7);
      #1 check(port_rdata_o, `RSS_NOP);
    end
    for (int i = split; i < upto; i++)
      note(i);
    while (running_o !== 1'b0 && n < 6000)
    begin
      @(negedge mclk_i);
      n++;
    end
    if (n >= 6000)
      errors++;
    repeat (3) @(posedge mclk_i);
    #1;
  endtask

  // radio side: every strobe pulse takes the oldest note
  always @(negedge mclk_i)
    if (strobe_o.valid === 1'b1)
    begin
      if (sq.size() == 0)
        check({1'b0, strobe_o}, 8'hff);
      else
        check({1'b0, strobe_o}, {1'b0, sq.pop_front()});
    end

  // watchdog well beyond the few thousand cycles the run needs
  initial
  begin
    repeat (40000) @(posedge mclk_i);
    errors++;
    end_of_test;
  end

  // main sequence
  initial
  begin
    void'($urandom(32'hae95));
    foreach (mem[i]) mem[i] = `RSS_NOP;
    repeat (5) @(posedge mclk_i);
    nrst_i <= 1'b1;
    @(posedge mclk_i);
    #1 check(port_rdata_o, `RSS_NOP);
    check(countdown_o, 8'h00);
    check({5'h0, flags_o}, 8'h00);
    wr(8'he5);
    // a later immediate would replace this one before its step
    repeat (26) @(posedge mclk_i);
    // loaded while idle; countdown off, x zero so the x wait falls through
    ry = $urandom;
    rz = $urandom;
    setp(0, `RSS_ALL_ONES);
    setp(1, 8'h00);
    setp(2, ry);
    setp(3, rz);
    foreach (prog_c[i]) wr(prog_c[i]);
    run(1, 24, 1'b1);
    y1 = ry + 8'h01;
    y2 = (y1 == 8'hff || y1 >= 8'h02) ? 8'h03 : y1 + 8'h01;
    check(param_y_o, y2);
    check(param_z_o, rz - 8'h01);
    check(param_x_o, 8'h00);
    check(countdown_o, `RSS_ALL_ONES);
    check({5'h0, flags_o}, 8'h07);
    check({7'h0, irq_o}, 8'h01);
    clr;
    run(24, 24, 1'b0);
    check({5'h0, flags_o}, 8'h07);
    clr;
    // pointer saturates: the last write replaces location 23
    wr(8'hff);
    repeat (23) wr(`RSS_NOP);
    wr(8'hc3);
    wr(8'hb9);
    clr;
    run(24, 24, 1'b0);
    check({5'h0, flags_o}, 8'h05);
    clr;
    // program stop halts before the interrupt and empties memory
    wr(8'hff);
    wr(8'hc4);
    wr(8'hdf);
    wr(8'hb9);
    clr;
    run(2, 2, 1'b0);
    check({5'h0, flags_o}, 8'h04);
    run(24, 24, 1'b0);
    clr;
    // countdown of three ends a 32-overflow wait early
    wr(8'hff);
    wr(8'h80);
    setp(0, 8'h03);
    clr;
    run(0, 0, 1'b0);
    check(countdown_o, 8'h00);
    check({5'h0, flags_o}, 8'h04);
    // skip past the end stops quietly
    wr(8'hff);
    setp(0, `RSS_ALL_ONES);
    cond_i <= 8'hff;
    repeat (22) wr(`RSS_NOP);
    wr(8'h70);
    clr;
    run(22, 22, 1'b0);
    check({5'h0, flags_o}, 8'h00);
    // compare wait, random load of three bits, label, negated loop back
    wr(8'hff);
    setp(2, 8'h03);
    clr;
    wr(8'hb8);
    wr(8'hbc);
    wr(8'hbe);
    wr(8'hba);
    wr(8'ha8);
    run(24, 24, 1'b0);
    check(param_x_o & 8'hf8, 8'h00);
    check(param_y_o, 8'h02);
    check({5'h0, flags_o}, 8'h04);
    check(8'(sq.size()), 8'h00);
    end_of_test;
  end
endmodule
`default_nettype wire
